// ===== hw/cmsr_reporter.sv
// Purpose: Forms single-byte receive-error reports and six-byte completion reports for the host.
// Assumes: Controller status bits are pins and are synchronised; other inputs are same-clock logic.
// Notes: One host word is presented at a time; a higher-priority source or a newer error byte can replace it before host_ack_in.
module cmsr_reporter #(
    parameter int FIFO_DEPTH = 8,
    parameter int CNT_W = 4
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [14:8] ctrl_err_bits_in,
    input wire logic rx_char_valid_in,
    input wire logic [7:0] rx_char_in,
    input wire logic detector_installed_in,
    input wire logic detector_return_in,
    input wire logic [15:0] error_mask_param_word_in,
    input wire logic [CNT_W-1:0] rx_threshold_in,
    input wire logic rx_timeout_in,
    input wire logic line_lost_in,
    input wire logic abort_in,
    input wire logic char_read_start_in,
    input wire logic cmd_done_in,
    input wire logic [6:0] cmd_code_in,
    input wire logic [7:0] cmd_opcode_in,
    input wire logic cmd_error_in,
    input wire logic [7:0] cmd_completion_in,
    input wire logic [31:0] cmd_info_in,
    input wire logic cmd_data_pending_in,
    input wire logic fatal_in,
    input wire logic [7:0] fatal_code_in,
    input wire logic host_ack_in,
    output logic [15:0] host_status_input_word_out,
    output logic host_word_valid_out,
    output logic host_irq_out,
    output logic char_read_mode_out,
    output logic report_busy_out,
    output logic [CNT_W-1:0] request_byte_count_out
);
    // One-hot codes keep each state decode to a single flop; the default branch
    // returns any illegal code to IDLE so an upset cannot wedge the reporter.
    typedef enum logic [3:0] {
        CMSR_IDLE = 4'b0001,
        CMSR_WAIT_DATA = 4'b0010,
        CMSR_SEND = 4'b0100,
        CMSR_DONE = 4'b1000
    } cmsr_state_t;

    cmsr_state_t state;
    cmsr_state_t next_state;
    logic [14:8] err_sync;
    logic [7:0] report [cmsr_pkg::REPORT_BYTES];
    logic [2:0] byte_idx;
    logic pend_byte_err;
    logic [7:0] err_byte;
    logic [7:0] data_byte;
    logic data_full;
    logic [CNT_W-1:0] data_cnt;
    logic [6:0] masked_err;
    logic err_hit;
    logic data_first;
    logic word_take;
    logic rpt_load;
    logic rpt_is_fatal;
    wire logic [7:0] status_byte;
    logic word_is_err_byte;
    logic word_is_data;

    // How the pieces fit together.
    // Three sources compete for the single host word: the six-byte completion report,
    // the one-byte receive-error report and the ordinary received character.
    // The completion report wins over both, and the error byte wins over data, so that
    // a host that drains the word in order always sees status before later data.
    // The error byte and the data byte are each released only by an ack of a word that
    // carries their own flag pattern; the report index advances on any ack while in SEND.
    // The host word is registered and trails the sequencer by one cycle; a host must
    // not ack a second time until the word has moved on, or it takes a stale copy.
    // Limitation: only one received character is held, so a character that arrives
    // while the previous one still waits for the host is dropped, not queued.
    // Reset clears every register; the first request is taken at the first enabled
    // edge after reset falls. While the clock enable is low nothing moves, and the
    // host word and its valid stay as they were.

    // Controller status pins are asynchronous to the board clock.
    // They pass two flops before the mask reads them, which costs two cycles of latency;
    // the controller holds its status for the whole character, so nothing is lost.
    // The first flop is read by the second only.
    cmsr_sync #(
        .WIDTH(7)
    ) u_err_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .async_in(ctrl_err_bits_in),
        .sync_out(err_sync)
    );

    // Only bits enabled in the mask upper byte raise a byte report.
    always_comb begin
        masked_err = err_sync & error_mask_param_word_in[14:8];
        err_hit = rx_char_valid_in && !detector_installed_in && (masked_err != 7'h00);
    end

    // The status byte is packed bit by bit so that the MSB-first numbering of the host
    // byte stays visible: byte bit 0 (the MSB) is undefined and sent as zero, and the
    // remaining bits carry controller bits 14 down to 8, the ninth data bit last.
    assign status_byte[7] = 1'b0;
    for (genvar k = 0; k < 7; k++) begin : g_status_bit
        assign status_byte[k] = err_sync[cmsr_pkg::CTRL_ERR_LO + k];
    end

    // Report-before-data commands are decoded from the opcode.
    // For these three commands the host needs the report to know what data follows,
    // so they skip the wait for pending data that a channel read must observe.
    assign data_first = (cmd_opcode_in == cmsr_pkg::CMD_READ_PARAMS) ||
                        (cmd_opcode_in == cmsr_pkg::CMD_RSV_MEM_STAT) ||
                        (cmd_opcode_in == cmsr_pkg::CMD_MEM_DUMP);
    assign word_take = host_word_valid_out && host_ack_in;
    // Flag pattern of the word now shown decides which source an ack releases.
    assign word_is_err_byte = host_status_input_word_out[cmsr_pkg::RESTART_BIT] &&
                              host_status_input_word_out[cmsr_pkg::STATUS_BIT];
    assign word_is_data = !host_status_input_word_out[cmsr_pkg::RESTART_BIT] &&
                          !host_status_input_word_out[cmsr_pkg::STATUS_BIT];
    assign rpt_load = (state == CMSR_IDLE) && (fatal_in || line_lost_in || cmd_done_in);
    assign rpt_is_fatal = fatal_in;

    // Character read mode ends only on abort, line loss or a fatal error, never on a byte report.
    // A receive error reported as a single byte leaves the mode running, so the host
    // keeps getting characters after it; only abort, line loss or a fatal error stop the mode.
    // Line loss and fatal errors end it because both close with a full report.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            char_read_mode_out <= 1'b0;
        end else if (ce_in) begin
            if (abort_in || line_lost_in || fatal_in) begin
                char_read_mode_out <= 1'b0;
            end else if (char_read_start_in) begin
                char_read_mode_out <= 1'b1;
            end
        end
    end

    // Status byte: MSB undefined (zero), then controller bits 14 down to 8.
    // The set is tested first, so a new error in the cycle of the ack is not lost;
    // the byte then shows the newer status, which is what the host wants to see.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pend_byte_err <= 1'b0;
            err_byte <= 8'h00;
        end else if (ce_in) begin
            if (err_hit && char_read_mode_out) begin
                pend_byte_err <= 1'b1;
                err_byte <= status_byte;
            end else if (word_take && word_is_err_byte) begin
                pend_byte_err <= 1'b0;
            end
        end
    end

    // One-entry holding byte plus a count toward the host threshold.
    // Only an ack of a data word empties it; acks of report or error words leave it,
    // so a character that came in during a report is still delivered afterwards.
    // The count clear is written last so that it wins over a same-cycle increment.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_full <= 1'b0;
            data_byte <= 8'h00;
            data_cnt <= '0;
        end else if (ce_in) begin
            if (rx_char_valid_in && !err_hit && char_read_mode_out && !data_full) begin
                data_full <= 1'b1;
                data_byte <= rx_char_in;
                data_cnt <= data_cnt + 1'b1;
            end else if (word_take && word_is_data) begin
                data_full <= 1'b0;
            end
            if (detector_return_in || rx_timeout_in || abort_in) begin
                data_cnt <= '0;
            end
        end
    end
    assign request_byte_count_out = data_cnt;

    // Interrupt per byte at threshold one, else when the count reaches threshold or times out.
    // Registered so that the host sees a clean level; it trails the word valid by a cycle,
    // which is harmless because the host reads the word only after the interrupt.
    // A receive timeout forces the interrupt so a group below threshold still drains.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            host_irq_out <= 1'b0;
        end else if (ce_in) begin
            host_irq_out <= (data_full && ((data_cnt >= rx_threshold_in) || rx_timeout_in ||
                             (rx_threshold_in <= cmsr_pkg::THRESH_RESET))) || pend_byte_err ||
                            (state == CMSR_SEND);
        end
    end

    // Completion report sequencer.
    // IDLE waits for a command end, a line loss or a fatal error.
    // WAIT_DATA holds a channel read report until the command has no data pending
    // and the holding byte is empty, so the report never overtakes its data.
    // SEND presents the six bytes in order, one per host ack.
    // DONE is one cycle of rest before a new report may load; requests then are refused.
    // Fatal errors and line loss never wait for data: the host must learn of them at once.
    always_comb begin
        next_state = state;
        case (state)
            CMSR_IDLE: begin
                if (rpt_load) begin
                    next_state = (cmd_data_pending_in && !data_first && !rpt_is_fatal && !line_lost_in)
                                 ? CMSR_WAIT_DATA : CMSR_SEND;
                end
            end
            CMSR_WAIT_DATA: begin
                if (!cmd_data_pending_in && !data_full) begin
                    next_state = CMSR_SEND;
                end
            end
            CMSR_SEND: begin
                if (word_take && (byte_idx == 3'(cmsr_pkg::REPORT_BYTES - 1))) begin
                    next_state = CMSR_DONE;
                end
            end
            CMSR_DONE: begin
                next_state = CMSR_IDLE;
            end
            default: begin
                next_state = CMSR_IDLE;
            end
        endcase
    end

    // State register; it holds with everything else while the clock enable is low.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= CMSR_IDLE;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    // Report bytes are built when the report is accepted for sending.
    // Capturing all six bytes at load time means later changes on the command inputs
    // cannot tear a report that is already on its way to the host.
    // Bytes 1 to 4 carry the command's own information, most significant byte first.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < cmsr_pkg::REPORT_BYTES; i++) begin
                report[i] <= 8'h00;
            end
        end else if (ce_in && rpt_load) begin
            if (rpt_is_fatal) begin
                report[0] <= cmsr_pkg::FATAL_BYTE0;
                report[cmsr_pkg::CODE_BYTE] <= fatal_code_in;
            end else if (line_lost_in) begin
                report[0] <= {1'b1, cmd_code_in};
                report[cmsr_pkg::CODE_BYTE] <= cmsr_pkg::CODE_DISCONNECT;
            end else begin
                report[0] <= {cmd_error_in, cmd_code_in};
                report[cmsr_pkg::CODE_BYTE] <= cmd_completion_in;
            end
            report[1] <= cmd_info_in[31:24];
            report[2] <= cmd_info_in[23:16];
            report[3] <= cmd_info_in[15:8];
            report[4] <= cmd_info_in[7:0];
        end
    end

    // Byte index; it advances only on an ack while sending and restarts outside SEND.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            byte_idx <= 3'h0;
        end else if (ce_in) begin
            if (state != CMSR_SEND) begin
                byte_idx <= 3'h0;
            end else if (word_take) begin
                byte_idx <= byte_idx + 3'h1;
            end
        end
    end

    // Host word: report bytes carry status flag only; error byte both flags; data neither.
    // Report first, then error byte, then data: status must never be buried under data.
    // The flag byte is 01 for a report, 03 for an error byte and 00 for data.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            host_status_input_word_out <= 16'h0000;
        end else if (ce_in) begin
            if (state == CMSR_SEND) begin
                host_status_input_word_out <= {8'h01, report[byte_idx]};
            end else if (pend_byte_err) begin
                host_status_input_word_out <= {8'h03, err_byte};
            end else begin
                host_status_input_word_out <= {8'h00, data_byte};
            end
        end
    end

    // Valid follows the sources directly so the host sees a request without delay.
    assign host_word_valid_out = (state == CMSR_SEND) || pend_byte_err || data_full;
    assign report_busy_out = (state != CMSR_IDLE);
endmodule : cmsr_reporter

// ===== hw/cmsr_pkg.sv
// Purpose: Constants shared by the character-mode status reporter.
// Assumes: Host input word is 16 bits, data byte in bits 7..0 (bit 7 is byte bit 0, the MSB).
// Notes: Contract
// Contract
// - Line loss uses six-byte completion report.
// - No detector: receive errors as one byte.
// - Single-byte report sets word bits 9, 8.
// - Data byte carries controller bits 8..14.
// - Async status byte layout, bit 0 undefined.
// - Byte bit 7 carries ninth data bit.
// - Read mode stays active after error byte.
// - Report only masked-in error bits; the code masks only the trigger, and the byte carries all synchronised bits.
// - Mask 1800 overrun/framing, 0400 parity.
// - No byte count kept after detector return.
// - Completion code sits in byte 5.
// - Channel read: report after all data.
// - Param/memory commands: report before data.
// - Error only when byte 0 MSB set.
// - Nonfatal: byte 0 low bits echo command.
// - Fatal: byte 0 is FF, unsolicited.
// - Bytes passed singly or at queue threshold.
package cmsr_pkg;
    localparam int WORD_W = 16;
    localparam int RESTART_BIT = 9;
    localparam int STATUS_BIT = 8;
    localparam int CTRL_ERR_LO = 8;
    localparam int CTRL_ERR_HI = 14;
    localparam int REPORT_BYTES = 6;
    localparam int CODE_BYTE = 5;
    localparam logic [15:0] MASK_RESET = 16'h1C00;
    localparam logic [15:0] MASK_OVR_FRM = 16'h1800;
    localparam logic [15:0] MASK_PARITY = 16'h0400;
    localparam logic [7:0] FATAL_BYTE0 = 8'hFF;
    localparam logic [7:0] CODE_DISCONNECT = 8'h18;
    localparam logic [7:0] CODE_OK = 8'h00;
    localparam logic [7:0] CMD_READ_PARAMS = 8'h74;
    localparam logic [7:0] CMD_RSV_MEM_STAT = 8'h2C;
    localparam logic [7:0] CMD_MEM_DUMP = 8'h1C;
    localparam logic [3:0] THRESH_RESET = 4'h1;
    localparam logic [15:0] TX_HOOK_NOP = 16'h1000;
    localparam logic [15:0] TX_HOOK_ON = 16'h1D10;
endpackage : cmsr_pkg

// ===== hw/cmsr_sync.sv
// Purpose: Two-flop synchroniser for a bus of levels from outside the clock domain.
// Assumes: Bits are independent levels.
// Notes: First stage is read by the second stage only.
module cmsr_sync #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // Both stages hold while the clock enable is low.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage1 <= '0;
            sync_out <= '0;
        end else if (ce_in) begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : cmsr_sync

// ===== testbench/cmsr_reporter_props.sv
// Purpose: Port-level checks for the character-mode status reporter.
// Assumes: One clock domain, reset high, CNT_W matches the instance.
// Notes: Report timing follows the walk: pending at c1, byte 0 on the word at c2.
module cmsr_reporter_props #(
    parameter int CNT_W = 4
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [14:8] ctrl_err_bits_in,
    input wire logic rx_char_valid_in,
    input wire logic detector_installed_in,
    input wire logic detector_return_in,
    input wire logic [15:0] error_mask_param_word_in,
    input wire logic line_lost_in,
    input wire logic abort_in,
    input wire logic cmd_done_in,
    input wire logic [7:0] cmd_opcode_in,
    input wire logic fatal_in,
    input wire logic [15:0] host_status_input_word_out,
    input wire logic host_word_valid_out,
    input wire logic char_read_mode_out,
    input wire logic report_busy_out,
    input wire logic [CNT_W-1:0] request_byte_count_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // A window long enough to drain the synchroniser with nothing enabled.
    sequence s_quiet;
        (((ctrl_err_bits_in & error_mask_param_word_in[14:8]) == 7'h00) || detector_installed_in)[*8];
    endsequence
    // A report request that the idle reporter must take.
    sequence s_fatal_go;
        fatal_in && ce_in && !report_busy_out;
    endsequence
    // The word checks run every cycle.
    a_upper_zero: assert property (host_status_input_word_out[15:10] == 6'h00)
        else $error("upper host word bits set");
    a_err_msb: assert property (host_status_input_word_out[9:8] == 2'b11 |-> !host_status_input_word_out[7])
        else $error("status byte top bit set");
    a_mask_gate: assert property (s_quiet |=> !$rose(host_word_valid_out && host_status_input_word_out[9:8] == 2'b11))
        else $error("unmasked error reported");
    a_line_loss: assert property (line_lost_in && ce_in && !report_busy_out |=> report_busy_out ##1
        host_status_input_word_out[9:8] == 2'b01)
        else $error("line loss not a full report");
    a_fatal_first: assert property (s_fatal_go |=> ##1 host_status_input_word_out == {8'h01, cmsr_pkg::FATAL_BYTE0})
        else $error("fatal byte 0 wrong");
    a_params_first: assert property (cmd_done_in && ce_in && !report_busy_out &&
        cmd_opcode_in == cmsr_pkg::CMD_READ_PARAMS |=> ##1 host_status_input_word_out[9:8] == 2'b01)
        else $error("parameter report delayed");
    a_count_clear: assert property (detector_return_in && ce_in && !rx_char_valid_in |=> request_byte_count_out == '0)
        else $error("byte count kept");
    a_mode_hold: assert property (char_read_mode_out && !(abort_in || line_lost_in || fatal_in || cmd_done_in)
        |=> char_read_mode_out)
        else $error("read mode dropped");
endmodule : cmsr_reporter_props

// ===== testbench/cmsr_host_model.sv
// Purpose: Host side that takes each presented word and keeps it in a queue.
// Assumes: Word settles one cycle after valid rises or after an ack.
// Notes: Waits two cycles of valid before acking, so it never takes a stale word.
module cmsr_host_model (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic hold_in,
    input wire logic host_word_valid_in,
    input wire logic [15:0] host_word_in,
    output logic host_ack_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] q[$];
    int cnt;
    // Terminal pacing as the detection routine performs it; the reporter has no transmit side.
    logic transmitter_on_bit = 1'b1;
    logic [15:0] tx_timeout_reload_word = 16'h0040;
    logic [15:0] active_tx_timeout_word = 16'h0040;
    logic [15:0] tx_enable_hook_slot = 16'h1D10;
    task automatic suspend_tx;
        transmitter_on_bit = 1'b0;
        active_tx_timeout_word = 16'h0000;
        tx_enable_hook_slot = cmsr_pkg::TX_HOOK_NOP;
    endtask : suspend_tx
    task automatic resume_tx;
        transmitter_on_bit = 1'b1;
        active_tx_timeout_word = tx_timeout_reload_word;
        tx_enable_hook_slot = cmsr_pkg::TX_HOOK_ON;
    endtask : resume_tx
    // Acks are launched on the falling edge so the design samples them cleanly.
    always @(negedge core_clk_in) begin
        if (rst_in || host_ack_out || !host_word_valid_in || hold_in) begin
            host_ack_out <= 1'b0;
            cnt <= 0;
        end else if (cnt < 2) begin
            cnt <= cnt + 1;
        end else begin
            host_ack_out <= 1'b1;
            q.push_back(host_word_in);
        end
    end
endmodule : cmsr_host_model

// ===== testbench/cmsr_reporter_tb.sv
// Purpose: Directed checks of byte reports, data words and six-byte reports.
// Assumes: Inputs change on the falling edge; host model acks every word.
// Notes: Timeout input is tied; threshold grouping is checked only for its interrupt.
module cmsr_reporter_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_in = 1'b0, rst_in = 1'b1, host_ack_in, host_word_valid_out, char_read_mode_out, report_busy_out;
    logic rx_char_valid_in = 0, detector_installed_in = 0, detector_return_in = 0, line_lost_in = 0, abort_in = 0;
    logic char_read_start_in = 0, cmd_done_in = 0, cmd_error_in = 0, cmd_data_pending_in = 0, fatal_in = 0;
    logic [14:8] ctrl_err_bits_in = '0;
    logic [7:0] rx_char_in = 0, cmd_opcode_in = 0, cmd_completion_in = 0, fatal_code_in = 8'h71;
    logic [6:0] cmd_code_in = 0;
    logic [15:0] error_mask_param_word_in = 0, host_status_input_word_out;
    logic [31:0] cmd_info_in = 32'h11223344;
    logic [3:0] request_byte_count_out, rx_threshold_in = 4'h1;
    logic host_irq_out;
    int error_cnt = 0, tests_run = 0;
    always #5 core_clk_in = ~core_clk_in;
    cmsr_reporter cmsr_reporter_i (.core_clk_in, .rst_in, .ce_in(1'b1), .ctrl_err_bits_in, .rx_char_valid_in,
        .rx_char_in, .detector_installed_in, .detector_return_in, .error_mask_param_word_in, .rx_threshold_in,
        .rx_timeout_in(1'b0), .line_lost_in, .abort_in, .char_read_start_in, .cmd_done_in, .cmd_code_in,
        .cmd_opcode_in, .cmd_error_in, .cmd_completion_in, .cmd_info_in, .cmd_data_pending_in, .fatal_in,
        .fatal_code_in, .host_ack_in, .host_status_input_word_out, .host_word_valid_out, .host_irq_out,
        .char_read_mode_out, .report_busy_out, .request_byte_count_out);
    cmsr_host_model cmsr_host_model_i (.core_clk_in, .rst_in, .hold_in(1'b0), .host_word_valid_in(host_word_valid_out),
        .host_word_in(host_status_input_word_out), .host_ack_out(host_ack_in));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge core_clk_in);
        s = 1'b0;
    endtask : pulse
    // Fixed settle time, then the host queue must hold exactly n words.
    task automatic settle(input int n, input logic [15:0] w);
        repeat (30) @(negedge core_clk_in);
        chk(16'(cmsr_host_model_i.q.size()), 16'(n));
        if (n > 0) chk(cmsr_host_model_i.q[0], w);
        cmsr_host_model_i.q.delete();
    endtask : settle
    task automatic err_case(input logic [6:0] bits, input logic [15:0] mask, input int n, input logic [15:0] w);
        error_mask_param_word_in = mask;
        ctrl_err_bits_in = bits;
        // Status settles through the synchroniser before the character that carries it.
        repeat (3) @(negedge core_clk_in);
        pulse(rx_char_valid_in);
        ctrl_err_bits_in = 7'h00;
        settle(n, w);
    endtask : err_case
    task automatic cmd(input logic [6:0] code, input logic [7:0] op, input logic err, input logic [7:0] cc);
        cmd_code_in = code;
        cmd_opcode_in = op;
        cmd_error_in = err;
        cmd_completion_in = cc;
        pulse(cmd_done_in);
    endtask : cmd
    // Waits, bounded, for a whole six-byte report and checks bytes 0 and 5.
    task automatic rpt(input logic [7:0] b0, input logic [7:0] b5);
        for (int k = 0; k < 400 && cmsr_host_model_i.q.size() < 6; k++) @(negedge core_clk_in);
        chk(16'(cmsr_host_model_i.q.size()), 16'd6);
        chk(cmsr_host_model_i.q[0], {8'h01, b0});
        chk(cmsr_host_model_i.q[5], {8'h01, b5});
        // Requests are refused until the sequencer is back in idle.
        repeat (3) @(negedge core_clk_in);
    endtask : rpt
    task automatic final_report;
        $display("checks=%0d errors=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    // Watchdog: the tests need under a thousand cycles, so five thousand means a hang.
    initial begin
        #50000;
        error_cnt++;
        final_report();
    end
    // Main sequence; each test prints one line when it ends.
    initial begin
        repeat (5) @(negedge core_clk_in);
        rst_in = 1'b0;
        chk({13'h0, host_word_valid_out, char_read_mode_out, report_busy_out}, 16'h0000);
        pulse(char_read_start_in);
        rx_char_in = 8'hA5;
        pulse(rx_char_valid_in);
        @(negedge core_clk_in);
        chk({15'h0, host_irq_out}, 16'h0001);
        settle(1, 16'h00A5);
        $display("test data done");
        err_case(7'h08, 16'h1800, 1, 16'h0308);
        err_case(7'h10, 16'h1800, 1, 16'h0310);
        err_case(7'h04, 16'h1800, 1, 16'h00A5);
        err_case(7'h05, 16'h0400, 1, 16'h0305);
        chk({15'h0, char_read_mode_out}, 16'h0001);
        detector_installed_in = 1'b1;
        err_case(7'h08, 16'h1800, 1, 16'h00A5);
        pulse(detector_return_in);
        chk({12'h0, request_byte_count_out}, 16'h0000);
        detector_installed_in = 1'b0;
        rx_threshold_in = 4'h2;
        pulse(rx_char_valid_in);
        @(negedge core_clk_in);
        chk({15'h0, host_irq_out}, 16'h0000);
        settle(1, 16'h00A5);
        rx_threshold_in = 4'h1;
        $display("test byte reports done");
        cmd(7'h12, 8'h12, 1'b1, 8'h13);
        rpt(8'h92, 8'h13);
        for (int i = 1; i < 5; i++) chk(cmsr_host_model_i.q[i], {8'h01, cmd_info_in[39-8*i -: 8]});
        cmsr_host_model_i.q.delete();
        cmd_data_pending_in = 1'b1;
        cmd(7'h09, 8'h09, 1'b0, 8'h00);
        settle(0, 16'h0000);
        cmd_data_pending_in = 1'b0;
        rpt(8'h09, 8'h00);
        cmsr_host_model_i.q.delete();
        cmd_data_pending_in = 1'b1;
        for (int j = 0; j < 3; j++) begin
            cmd_opcode_in = (j == 0) ? 8'h74 : ((j == 1) ? 8'h2C : 8'h1C);
            cmd(cmd_opcode_in[6:0], cmd_opcode_in, 1'b0, 8'h00);
            rpt({1'b0, cmd_opcode_in[6:0]}, 8'h00);
            cmsr_host_model_i.q.delete();
        end
        cmd_data_pending_in = 1'b0;
        $display("test completion reports done");
        pulse(line_lost_in);
        rpt({1'b1, cmd_code_in}, 8'h18);
        cmsr_host_model_i.q.delete();
        pulse(fatal_in);
        rpt(8'hFF, 8'h71);
        $display("test line and fatal done");
        cmsr_host_model_i.suspend_tx();
        chk(cmsr_host_model_i.tx_enable_hook_slot, 16'h1000);
        chk(cmsr_host_model_i.active_tx_timeout_word, 16'h0000);
        chk({15'h0, cmsr_host_model_i.transmitter_on_bit}, 16'h0000);
        cmsr_host_model_i.resume_tx();
        chk(cmsr_host_model_i.tx_enable_hook_slot, 16'h1D10);
        chk(cmsr_host_model_i.active_tx_timeout_word, 16'h0040);
        chk({15'h0, cmsr_host_model_i.transmitter_on_bit}, 16'h0001);
        $display("test pacing done");
        final_report();
    end
endmodule : cmsr_reporter_tb
bind cmsr_reporter cmsr_reporter_props #(.CNT_W(CNT_W)) cmsr_reporter_props_i (.core_clk_in, .rst_in, .ce_in,
    .ctrl_err_bits_in, .rx_char_valid_in, .detector_installed_in, .detector_return_in, .error_mask_param_word_in,
    .line_lost_in, .abort_in, .cmd_done_in, .cmd_opcode_in, .fatal_in, .host_status_input_word_out,
    .host_word_valid_out, .char_read_mode_out, .report_busy_out, .request_byte_count_out);
